// *** oag_bit_unit.sv ***
// Purpose: shared constants and helpers for the operand address
//          generator, plus the single-bit test/modify datapath.
// Assumes: one 10 MHz clock domain; memory answers in the same cycle.
// Notes:   the bit unit is purely combinational.
`timescale 1ns/1ps
package oag_pkg;
  localparam int ADDR_W = 16; // full address width presented to memory
  localparam int DATA_W = 8; // byte-wide memory
  localparam logic [ADDR_W-1:0] PC_RST = 16'h0000; // pc after reset
  localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00; // cleared byte
  localparam logic [DATA_W-1:0] DDR_READ_VAL = 8'hff; // undefined read
  localparam logic [ADDR_W-1:0] DDR_FIRST = 16'h0004; // port a direction
  localparam logic [ADDR_W-1:0] DDR_LAST = 16'h0006; // port c direction
  localparam logic [ADDR_W-1:0] ONE_STEP = 16'h0001; // pc increment
  // opcode field positions
  localparam int OP_HI_LSB = 4; // high nibble selects the mode group
  localparam int BIT_SEL_LSB = 1; // bit number sits in op[3:1]
  localparam int BIT_POL_POS = 0; // op[0]: clear/low variant
  localparam logic [DATA_W-1:0] OP_SUB_REL = 8'had; // subroutine branch

  // ten ways of finding an operand
  typedef enum logic [3:0] {
    MODE_IMM = 4'h0,
    MODE_DIR = 4'h1,
    MODE_EXT = 4'h2,
    MODE_REL = 4'h3,
    MODE_IX0 = 4'h4,
    MODE_IX8 = 4'h5,
    MODE_IX16 = 4'h6,
    MODE_BSC = 4'h7,
    MODE_BTB = 4'h8,
    MODE_INH = 4'h9
  } oag_mode_t;

  // opcode to addressing mode
  function automatic oag_mode_t oag_decode(input logic [7:0] op);
    oag_mode_t m;
    m = MODE_INH;
    case (op[7:4])
      4'h0: m = MODE_BTB;
      4'h1: m = MODE_BSC;
      4'h2: m = MODE_REL;
      4'h3: m = MODE_DIR;
      4'h6: m = MODE_IX8;
      4'h7: m = MODE_IX0;
      4'ha: m = (op == OP_SUB_REL) ? MODE_REL : MODE_IMM;
      4'hb: m = MODE_DIR;
      4'hc: m = MODE_EXT;
      4'hd: m = MODE_IX16;
      4'he: m = MODE_IX8;
      4'hf: m = MODE_IX0;
      default: m = MODE_INH;
    endcase
    return m;
  endfunction : oag_decode

  // instruction length in bytes, opcode included
  function automatic logic [1:0] oag_length(input oag_mode_t m);
    logic [1:0] n;
    n = 2'h2;
    case (m)
      MODE_INH, MODE_IX0: n = 2'h1;
      MODE_EXT, MODE_IX16, MODE_BTB: n = 2'h3;
      default: n = 2'h2;
    endcase
    return n;
  endfunction : oag_length

  // write-only direction registers give no defined read
  function automatic logic oag_is_ddr(input logic [ADDR_W-1:0] a);
    return (a >= DDR_FIRST) && (a <= DDR_LAST);
  endfunction : oag_is_ddr

  // signed byte offset widened to the address width
  function automatic logic [ADDR_W-1:0] oag_sext(input logic [7:0] b);
    return {{(ADDR_W-DATA_W){b[7]}}, b};
  endfunction : oag_sext
endpackage : oag_pkg

// single-bit test and set/clear on one byte
module oag_bit_unit
  import oag_pkg::*;
(
  input wire logic [7:0] data_in, // byte as read
  input wire logic [2:0] bit_sel_in, // bit number from opcode
  input wire logic clear_in, // 1 clears, 0 sets
  output logic tested_out, // current state of the chosen bit
  output logic [7:0] result_out // byte with the bit changed
);
  logic [7:0] mask; // one-hot select of the bit

  // whole byte is rewritten, so all other bits pass through as read
  always_comb
  begin
    mask = 8'h01 << bit_sel_in;
    tested_out = |(data_in & mask);
    result_out = clear_in ? (data_in & ~mask) : (data_in | mask);
  end
endmodule : oag_bit_unit

// *** oag_mem_model.sv ***
// Purpose: memory and i/o space answering the generator
// Assumes: read data valid in the same cycle as the strobe
// Notes:   direction registers read back garbage
`timescale 1ns/1ps
module oag_mem_model
  import oag_pkg::*;
(
  input wire logic clk_in,
  input wire logic [15:0] addr_in,
  input wire logic rd_in,
  input wire logic wr_in,
  input wire logic [7:0] wdata_in,
  output logic [7:0] rdata_out
);
  logic [7:0] mem [0:65535]; // whole space
  logic [7:0] churn_r = 8'ha5; // differs every cycle
  logic ddr_hit; // write-only place addressed
  // stores land on the edge, churn keeps stale reads from passing
  // plain always: the bench preloads the array through the hierarchy
  always @(posedge clk_in)
  begin
    churn_r <= churn_r + 8'h5b;
    if (wr_in)
      mem[addr_in] <= wdata_in;
  end
  assign ddr_hit = addr_in >= 16'h0004 && addr_in <= 16'h0006;
  // unselected bus gives no stale value
  assign rdata_out = (!rd_in || ddr_hit) ? churn_r :
                     mem[addr_in];
endmodule : oag_mem_model

// *** oag_operand_address_generator.sv ***
// Purpose: fetches opcode and argument bytes, forms operand locations
//          and branch targets, runs single-bit read-modify-write.
// Assumes: memory read data is valid in the cycle the read is driven;
//          branch condition for relative branches is given at start.
// Notes:   one instruction at a time; start is ignored while busy.
`timescale 1ns/1ps

// Notes on behaviour
// RULE1: immediate operand is byte after opcode
// RULE2: direct uses next byte, low 256 bytes
// RULE3: extended forms address from two next bytes
// RULE4: relative offset added only if condition holds
// RULE5: indexed no offset uses index register
// RULE6: 8-bit offset plus index, no wrap
// RULE7: 16-bit offset plus index reaches everywhere
// RULE8: bit set/clear: bit from opcode, address next
// RULE9: direction registers write-only, reads undefined
// RULE10: bit set/clear rewrites whole byte
// RULE11: bit test branch: bit, polarity, address, offset
// RULE12: tested bit copied into carry always
// RULE13: inherent instructions are one byte
// RULE14: carry propagates into high address byte
module oag_operand_address_generator
  import oag_pkg::*;
(
  input wire logic clk_in, // core clock, 10 MHz
  input wire logic sys_rst_in, // async reset, active high
  input wire logic start_in, // pulse: begin one instruction
  input wire logic [15:0] pc_in, // opcode address
  input wire logic [7:0] index_in, // index register value
  input wire logic branch_cond_in, // relative branch condition true
  input wire logic [7:0] mem_rdata_in, // memory read data
  output logic [15:0] mem_addr_out, // memory address
  output logic mem_rd_out, // memory read strobe
  output logic mem_wr_out, // memory write strobe
  output logic [7:0] mem_wdata_out, // memory write data
  output logic busy_out, // instruction in progress
  output logic done_out, // pulse: results valid
  output logic [3:0] mode_out, // decoded addressing mode
  output logic [1:0] length_out, // instruction bytes
  output logic [7:0] opcode_out, // fetched opcode
  output logic [15:0] operand_location_out, // effective address
  output logic [7:0] operand_out, // immediate or bit-op byte
  output logic [15:0] program_counter_out, // next instruction address
  output logic carry_out, // carry value to load
  output logic carry_we_out // pulse: load carry flag
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_OPC = 3'h1,
    ST_ARG1 = 3'h2,
    ST_ARG2 = 3'h3,
    ST_CALC = 3'h4,
    ST_READ = 3'h5,
    ST_WRITE = 3'h6,
    ST_DONE = 3'h7
  } oag_state_t;

  oag_state_t state_r; // sequencer state
  oag_state_t state_nxt; // next sequencer state
  logic [15:0] pc_r; // fetch pointer, ends past the instruction
  logic [7:0] idx_r; // index register snapshot
  logic cond_r; // branch condition snapshot
  logic [7:0] opc_r; // opcode byte
  logic [7:0] arg1_r; // first byte after opcode
  logic [7:0] arg2_r; // second byte after opcode
  oag_mode_t mode_r; // decoded mode
  logic [15:0] loc_r; // effective address
  logic [15:0] loc_calc; // effective address before latching
  logic [15:0] npc_r; // next program counter
  logic [7:0] opnd_r; // operand byte result
  logic [7:0] wdata_r; // byte to write back
  logic carry_r; // tested bit
  logic carry_we_r; // carry load strobe
  logic [7:0] rdata_eff; // read data with direction-register masking
  logic bit_now; // tested bit of the byte being read
  logic [7:0] bit_res; // modified byte
  logic taken; // branch goes to target
  logic [7:0] rel_off; // offset byte for this branch kind
  oag_mode_t mode_dec; // mode from the byte on the bus

  assign mode_dec = oag_decode(mem_rdata_in);

  // reads of a direction register are undefined; all ones is used, so a
  // bit set/clear leaves the untouched bits set
  assign rdata_eff = oag_is_ddr(loc_r) ? DDR_READ_VAL :
                     mem_rdata_in; // see RULE9

  oag_bit_unit u_bit (
    .data_in(rdata_eff),
    .bit_sel_in(opc_r[BIT_SEL_LSB +: 3]), // see RULE8
    .clear_in(opc_r[BIT_POL_POS]),
    .tested_out(bit_now),
    .result_out(bit_res)
  );

  // effective address per mode
  always_comb
  begin
    loc_calc = {BYTE_ZERO, arg1_r};
    case (mode_r)
      MODE_DIR: loc_calc = {BYTE_ZERO, arg1_r}; // see RULE2
      MODE_EXT: loc_calc = {arg1_r, arg2_r}; // see RULE3
      MODE_IX0: loc_calc = {BYTE_ZERO, idx_r}; // see RULE5
      // nine-bit sum kept whole, reaching 510
      MODE_IX8:
        loc_calc = {7'h00, {1'b0, idx_r} + {1'b0, arg1_r}}; // see RULE6
      // sixteen-bit sum, low-byte carry ripples into the high byte
      MODE_IX16:
        loc_calc = {arg1_r, arg2_r} + {BYTE_ZERO, idx_r}; // see RULE7, RULE14
      MODE_BSC: loc_calc = {BYTE_ZERO, arg1_r}; // see RULE8
      MODE_BTB: loc_calc = {BYTE_ZERO, arg1_r}; // see RULE11
      MODE_IMM: loc_calc = pc_r - ONE_STEP; // operand's own location
      default: loc_calc = PC_RST;
    endcase
  end

  // branch decision; op[0] low means branch on bit high
  always_comb
  begin
    taken = 1'b0;
    rel_off = arg1_r;
    case (mode_r)
      MODE_REL: taken = cond_r; // see RULE4
      MODE_BTB:
      begin
        rel_off = arg2_r;
        taken = (state_r == ST_READ) &&
                (bit_now != opc_r[BIT_POL_POS]); // see RULE11
      end
      default: taken = 1'b0;
    endcase
  end

  // sequencing
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: state_nxt = start_in ? ST_OPC : ST_IDLE;
      // one-byte modes go straight to calculation
      ST_OPC: // see RULE13
        state_nxt = (oag_length(mode_dec) == 2'h1) ? ST_CALC : ST_ARG1;
      ST_ARG1: state_nxt = (oag_length(mode_r) == 2'h3) ? ST_ARG2 : ST_CALC;
      ST_ARG2: state_nxt = ST_CALC;
      ST_CALC:
      begin
        if ((mode_r == MODE_BSC) || (mode_r == MODE_BTB))
          state_nxt = ST_READ;
        else
          state_nxt = ST_DONE;
      end
      ST_READ: state_nxt = (mode_r == MODE_BSC) ? ST_WRITE : ST_DONE;
      ST_WRITE: state_nxt = ST_DONE;
      ST_DONE: state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      state_r <= ST_IDLE;
    else
      state_r <= state_nxt;
  end

  // snapshot of core state at start; fetch pointer walks the bytes
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      pc_r <= PC_RST;
      idx_r <= BYTE_ZERO;
      cond_r <= 1'b0;
    end
    else if ((state_r == ST_IDLE) && start_in)
    begin
      pc_r <= pc_in;
      idx_r <= index_in;
      cond_r <= branch_cond_in;
    end
    else if ((state_r == ST_OPC) || (state_r == ST_ARG1) ||
             (state_r == ST_ARG2))
      pc_r <= pc_r + ONE_STEP;
  end

  // instruction bytes
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      opc_r <= BYTE_ZERO;
      arg1_r <= BYTE_ZERO;
      arg2_r <= BYTE_ZERO;
      mode_r <= MODE_INH;
    end
    else
    begin
      case (state_r)
        ST_OPC:
        begin
          opc_r <= mem_rdata_in;
          mode_r <= mode_dec;
        end
        ST_ARG1: arg1_r <= mem_rdata_in;
        ST_ARG2: arg2_r <= mem_rdata_in;
        default: opc_r <= opc_r;
      endcase
    end
  end

  // effective address and next program counter
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      loc_r <= PC_RST;
      npc_r <= PC_RST;
    end
    else if (state_r == ST_CALC)
    begin
      loc_r <= loc_calc;
      npc_r <= pc_r + (taken ? oag_sext(rel_off) : PC_RST); // see RULE4
    end
    else if ((state_r == ST_READ) && (mode_r == MODE_BTB))
      npc_r <= pc_r + (taken ? oag_sext(rel_off) : PC_RST); // see RULE11
  end

  // operand byte, write-back byte and carry
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      opnd_r <= BYTE_ZERO;
      wdata_r <= BYTE_ZERO;
      carry_r <= 1'b0;
      carry_we_r <= 1'b0;
    end
    else
    begin
      carry_we_r <= 1'b0;
      if (state_r == ST_CALC)
        // immediate value already sits in the first argument byte
        opnd_r <= (mode_r == MODE_IMM) ? arg1_r : BYTE_ZERO; // see RULE1
      else if (state_r == ST_READ)
      begin
        if (mode_r == MODE_BSC)
        begin
          wdata_r <= bit_res; // see RULE10
          opnd_r <= bit_res;
        end
        else
        begin
          opnd_r <= rdata_eff;
          carry_r <= bit_now; // see RULE12
          carry_we_r <= 1'b1; // taken or not
        end
      end
    end
  end

  // memory port: fetches use pc, bit ops use the effective address
  always_comb
  begin
    mem_addr_out = pc_r;
    mem_rd_out = 1'b0;
    mem_wr_out = 1'b0;
    case (state_r)
      ST_OPC, ST_ARG1, ST_ARG2: mem_rd_out = 1'b1;
      ST_READ:
      begin
        mem_addr_out = loc_r;
        mem_rd_out = 1'b1;
      end
      ST_WRITE:
      begin
        mem_addr_out = loc_r;
        mem_wr_out = 1'b1; // see RULE10
      end
      default: mem_rd_out = 1'b0;
    endcase
  end

  assign mem_wdata_out = wdata_r;
  assign busy_out = (state_r != ST_IDLE);
  assign done_out = (state_r == ST_DONE);
  assign mode_out = mode_r;
  assign length_out = oag_length(mode_r);
  assign opcode_out = opc_r;
  assign operand_location_out = loc_r;
  assign operand_out = opnd_r;
  assign program_counter_out = npc_r;
  assign carry_out = carry_r;
  // carry strobe lines up with done for bit test and branch
  assign carry_we_out = carry_we_r;
endmodule : oag_operand_address_generator

// *** oag_properties.sv ***
// Purpose: timing and address checks on the operand address generator
// Assumes: one clock domain, asynchronous active-high reset
// Notes:   watches design ports only (start_in, pc_in and outputs)
`timescale 1ns/1ps
module oag_properties
  import oag_pkg::*;
(
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic start_in,
  input wire logic [15:0] pc_in,
  input wire logic [15:0] mem_addr_out,
  input wire logic mem_rd_out,
  input wire logic mem_wr_out,
  input wire logic busy_out,
  input wire logic done_out,
  input wire logic [3:0] mode_out,
  input wire logic [1:0] length_out,
  input wire logic [15:0] operand_location_out,
  input wire logic carry_we_out
);
  logic [1:0] exp_len; // byte count implied by the mode
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);
  // length table kept apart from the design's own helper
  always_comb
  begin
    case (mode_out)
      4'h9, 4'h4: exp_len = 2'h1;
      4'h2, 4'h6, 4'h8: exp_len = 2'h3;
      default: exp_len = 2'h2;
    endcase
  end
  sequence s_take;
    start_in && !busy_out;
  endsequence
  sequence s_read_back;
    $past(mem_rd_out) && mem_addr_out == $past(mem_addr_out);
  endsequence
  fetch_opcode_a: assert property (
    s_take |=> busy_out && mem_rd_out && mem_addr_out == $past(pc_in))
    else $error("opcode fetch missing");
  answer_time_a: assert property (
    s_take |-> ##[3:7] done_out)
    else $error("no done in time");
  done_pulse_a: assert property (
    done_out |=> !done_out && !busy_out)
    else $error("done not a pulse");
  length_a: assert property (
    done_out |-> length_out == exp_len)
    else $error("bad length");
  direct_page_a: assert property (
    done_out && mode_out == MODE_DIR |-> operand_location_out[15:8] == 8'h00)
    else $error("direct off page");
  index_page_a: assert property (
    done_out && mode_out == MODE_IX0 |-> operand_location_out[15:8] == 8'h00)
    else $error("index off page");
  index_reach_a: assert property (
    done_out && mode_out == MODE_IX8 |-> operand_location_out <= 16'h01fe)
    else $error("index reach");
  bit_page_a: assert property (
    done_out && (mode_out == MODE_BSC || mode_out == MODE_BTB) |->
    operand_location_out[15:8] == 8'h00)
    else $error("bit off page");
  write_rmw_a: assert property (
    mem_wr_out |-> s_read_back ##1 done_out)
    else $error("write not rmw");
  carry_load_a: assert property (
    carry_we_out == (done_out && mode_out == MODE_BTB))
    else $error("carry load");
endmodule : oag_properties

bind oag_operand_address_generator oag_properties oag_properties_i (
  .clk_in(clk_in), .sys_rst_in(sys_rst_in), .start_in(start_in),
  .pc_in(pc_in), .mem_addr_out(mem_addr_out), .mem_rd_out(mem_rd_out),
  .mem_wr_out(mem_wr_out), .busy_out(busy_out), .done_out(done_out),
  .mode_out(mode_out), .length_out(length_out),
  .operand_location_out(operand_location_out),
  .carry_we_out(carry_we_out));

// *** operand_address_generator_bench.sv ***
// Purpose: self-checking bench for the operand address generator
// Assumes: inputs change on the falling edge
// Notes:   each scenario is one task
`timescale 1ns/1ps
module operand_address_generator_bench
  import oag_pkg::*;
;
  logic clk_in, sys_rst_in, start_in, branch_cond_in;
  logic [15:0] pc_in, mem_addr_out, operand_location_out, program_counter_out;
  logic [7:0] index_in, mem_rdata_in, mem_wdata_out, opcode_out, operand_out;
  logic mem_rd_out, mem_wr_out, busy_out, done_out, carry_out, carry_we_out;
  logic [3:0] mode_out;
  logic [1:0] length_out;
  logic cw_seen; // carry load seen in done cycle
  int err_total, num_checks;
  oag_operand_address_generator oag_operand_address_generator_i (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .start_in(start_in),
    .pc_in(pc_in), .index_in(index_in), .branch_cond_in(branch_cond_in),
    .mem_rdata_in(mem_rdata_in), .mem_addr_out(mem_addr_out),
    .mem_rd_out(mem_rd_out), .mem_wr_out(mem_wr_out),
    .mem_wdata_out(mem_wdata_out), .busy_out(busy_out),
    .done_out(done_out), .mode_out(mode_out), .length_out(length_out),
    .opcode_out(opcode_out), .operand_location_out(operand_location_out),
    .operand_out(operand_out), .program_counter_out(program_counter_out),
    .carry_out(carry_out), .carry_we_out(carry_we_out));
  oag_mem_model oag_mem_model_i (.clk_in(clk_in), .addr_in(mem_addr_out),
    .rd_in(mem_rd_out), .wr_in(mem_wr_out), .wdata_in(mem_wdata_out),
    .rdata_out(mem_rdata_in));
  initial
  begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  task automatic chk(input string nm, input logic [15:0] seen,
                     input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wrap_up();
    if (err_total == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : wrap_up
  // one instruction, waits for done under a bound
  task automatic run(input logic [15:0] p, input logic [7:0] op, a1, a2, ix,
                     input logic c);
    int n;
    @(negedge clk_in);
    oag_mem_model_i.mem[p] = op;
    oag_mem_model_i.mem[p+16'h0001] = a1;
    oag_mem_model_i.mem[p+16'h0002] = a2;
    pc_in = p;
    index_in = ix;
    branch_cond_in = c;
    start_in = 1'b1;
    @(negedge clk_in);
    start_in = 1'b0;
    n = 0;
    while (done_out !== 1'b1 && n < 20)
    begin
      @(negedge clk_in);
      n++;
    end
    chk("done", done_out, 1'b1);
    chk("opc", opcode_out, {8'h00, op});
    cw_seen = carry_we_out;
  endtask : run
  // reset in mid-fetch, then a clean instruction must still run
  task automatic t_reset();
    @(negedge clk_in);
    oag_mem_model_i.mem[16'h0700] = 8'hc6;
    pc_in = 16'h0700;
    start_in = 1'b1;
    @(negedge clk_in);
    start_in = 1'b0;
    @(negedge clk_in);
    sys_rst_in = 1'b1;
    repeat (2) @(negedge clk_in);
    chk("rst", {busy_out, done_out, mem_rd_out, mem_wr_out}, 4'h0);
    chk("rstpc", program_counter_out, 16'h0000);
    sys_rst_in = 1'b0;
    run(16'h0710, 8'hbe, 8'h33, 8'h00, 8'h00, 1'b0);
    chk("rdir", operand_location_out, 16'h0033);
  endtask : t_reset
  task automatic t_simple();
    run(16'h0100, 8'ha6, 8'h55, 8'h00, 8'h00, 1'b0);
    chk("imm", operand_out, 8'h55);
    chk("immpc", program_counter_out, 16'h0102);
    run(16'h0110, 8'hb6, 8'h80, 8'h00, 8'h00, 1'b0);
    chk("dir", operand_location_out, 16'h0080);
    chk("dmode", {mode_out, length_out}, {4'h1, 2'h2});
    run(16'h0120, 8'hc6, 8'h12, 8'h34, 8'h00, 1'b0);
    chk("ext", operand_location_out, 16'h1234);
    chk("extpc", program_counter_out, 16'h0123);
    run(16'h0600, 8'h4c, 8'h00, 8'h00, 8'h00, 1'b0);
    chk("inh", program_counter_out, 16'h0601);
  endtask : t_simple
  task automatic t_rel();
    run(16'h0200, 8'h20, 8'h80, 8'h00, 8'h00, 1'b1);
    chk("back", program_counter_out, 16'h0182);
    run(16'h0200, 8'h20, 8'h7f, 8'h00, 8'h00, 1'b1);
    chk("fwd", program_counter_out, 16'h0281);
    run(16'h0200, 8'h20, 8'h7f, 8'h00, 8'h00, 1'b0);
    chk("skip", program_counter_out, 16'h0202);
  endtask : t_rel
  task automatic t_idx();
    run(16'h0300, 8'hf6, 8'h00, 8'h00, 8'hff, 1'b0);
    chk("ix0", operand_location_out, 16'h00ff);
    chk("ix0len", length_out, 2'h1);
    run(16'h0310, 8'he6, 8'hff, 8'h00, 8'hff, 1'b0);
    chk("ix8", operand_location_out, 16'h01fe);
    run(16'h0320, 8'hd6, 8'h12, 8'hf0, 8'h20, 1'b0);
    chk("ix16", operand_location_out, 16'h1310);
    chk("ix16len", {mode_out, length_out}, {4'h6, 2'h3});
  endtask : t_idx
  task automatic t_bits();
    oag_mem_model_i.mem[16'h0040] = 8'h00;
    oag_mem_model_i.mem[16'h0041] = 8'hff;
    run(16'h0400, 8'h16, 8'h40, 8'h00, 8'h00, 1'b0);
    chk("set", oag_mem_model_i.mem[16'h0040], 8'h08);
    chk("wdat", mem_wdata_out, 8'h08);
    run(16'h0410, 8'h17, 8'h41, 8'h00, 8'h00, 1'b0);
    chk("clr", oag_mem_model_i.mem[16'h0041], 8'hf7);
    run(16'h0420, 8'h10, 8'h04, 8'h00, 8'h00, 1'b0);
    chk("ddr", oag_mem_model_i.mem[16'h0004], 8'hff);
  endtask : t_bits
  task automatic t_btb();
    run(16'h0500, 8'h06, 8'h40, 8'h7f, 8'h00, 1'b0);
    chk("hi", program_counter_out, 16'h0582);
    chk("hibyte", operand_out, 8'h08);
    chk("cy", {cw_seen, carry_out}, 2'h3);
    run(16'h0510, 8'h07, 8'h40, 8'h7f, 8'h00, 1'b0);
    chk("lo", program_counter_out, 16'h0513);
    chk("cy2", {cw_seen, carry_out}, 2'h3);
    run(16'h0520, 8'h0f, 8'h40, 8'h80, 8'h00, 1'b0);
    chk("lo7", program_counter_out, 16'h04a3);
    chk("cy3", {cw_seen, carry_out}, 2'h2);
  endtask : t_btb
  // watchdog: whole run is about 110 cycles
  initial
  begin
    #100000;
    err_total++;
    wrap_up();
  end
  initial
  begin
    sys_rst_in = 1'b1;
    {start_in, branch_cond_in, pc_in, index_in} = '0;
    repeat (8) @(negedge clk_in);
    sys_rst_in = 1'b0;
    t_simple();
    t_rel();
    t_idx();
    t_bits();
    t_btb();
    t_reset();
    wrap_up();
  end
endmodule : operand_address_generator_bench
